// [rtl/fesp_defs.vh]
`ifndef FESP_DEFS_VH
`define FESP_DEFS_VH
// =========================================
// Controller register map (word index on the local port)
`define FESP_REG_CMD 4'h0
`define FESP_REG_STATUS 4'h1
`define FESP_REG_ADDR 4'h2
`define FESP_REG_WDATA 4'h3
`define FESP_REG_RDATA 4'h4
`define FESP_REG_CTRL 4'h5
// Command register codes
`define FESP_CMD_CHIP_ERASE 3'h1
`define FESP_CMD_SUSPEND 3'h2
`define FESP_CMD_READ 3'h3
`define FESP_CMD_RESET 3'h4
// Flash command codes and addresses
`define FESP_FL_ADDR_555 20'h0_0555
`define FESP_FL_ADDR_2AA 20'h0_02AA
`define FESP_FL_DATA_AA 16'h00AA
`define FESP_FL_DATA_55 16'h0055
`define FESP_FL_DATA_80 16'h0080
`define FESP_FL_DATA_10 16'h0010
`define FESP_FL_DATA_B0 16'h00B0
// Status bit positions in flash data
`define FESP_BIT_POLL 7
`define FESP_BIT_TOGGLE 6
`define FESP_BIT_SECTOR 2
// Status register bits
`define FESP_ST_BUSY 0
`define FESP_ST_DONE 1
`define FESP_ST_ERR 2
`define FESP_ST_REFUSED 3
`define FESP_ST_RDY 4
// Timing in ns and cycles at 100 ns period
`define FESP_CLK_NS 100
`define FESP_PULSE_NS 200
`define FESP_PULSE_CYC ((`FESP_PULSE_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_SETTLE_NS 1000
`define FESP_SETTLE_CYC ((`FESP_SETTLE_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_RST_PULSE_NS 1000
`define FESP_RST_PULSE_CYC ((`FESP_RST_PULSE_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_RST_REC_NS 1000
`define FESP_RST_REC_CYC ((`FESP_RST_REC_NS + `FESP_CLK_NS - 1) / `FESP_CLK_NS)
`define FESP_NSEQ 6
`endif

// [rtl/fesp_host.v]
`timescale 1ns/1ps
`default_nettype none
`include "fesp_defs.vh"
module fesp_host
(
   // Clock and reset
   input wire mclk_in,
   input wire resetn_in,
   // Local register port
   input wire [3:0] addr_in,
   input wire [15:0] wdata_in,
   input wire wr_in,
   input wire rd_in,
   output reg [15:0] rdata_out,
   // Flash pins
   output reg [19:0] fl_addr_out,
   input wire [15:0] fl_dq_in,
   output reg [15:0] fl_dq_out,
   output reg fl_dq_oe_n_out,
   output reg fl_ce_n_out,
   output reg fl_we_n_out,
   output reg fl_oe_n_out,
   output reg fl_rst_n_out,
   output reg fl_wp_n_out,
   input wire ready_busy_n_in
);
   // =========================================
   // States
   localparam S_IDLE = 8'h01;
   localparam S_WLOW = 8'h02;
   localparam S_WHIGH = 8'h04;
   localparam S_RLOW = 8'h08;
   localparam S_RHIGH = 8'h10;
   localparam S_SETTLE = 8'h20;
   localparam S_RST = 8'h40;
   localparam S_REC = 8'h80;

   reg [7:0] state;
   reg [2:0] seq_idx;
   reg [2:0] seq_len;
   reg [3:0] cnt;
   reg [1:0] confirm;
   reg polling;
   reg single_read;
   reg toggle_prev;
   reg have_prev;
   reg busy;
   reg done;
   reg err;
   reg refused;
   reg [19:0] user_addr;
   reg [15:0] user_wdata;
   reg [15:0] last_read;

   // Sequence table: address of each write
   function [19:0] seq_addr;
      input [2:0] idx;
      begin
         case (idx)
            3'h1: seq_addr = `FESP_FL_ADDR_2AA;
            3'h4: seq_addr = `FESP_FL_ADDR_2AA;
            default: seq_addr = `FESP_FL_ADDR_555;
         endcase
      end
   endfunction

   // Sequence table: data of each write; short sequence is suspend
   function [15:0] seq_data;
      input [2:0] idx;
      input [2:0] len;
      begin
         if (len == 3'h1)
            seq_data = `FESP_FL_DATA_B0;
         else
         begin
            case (idx)
               3'h0: seq_data = `FESP_FL_DATA_AA;
               3'h1: seq_data = `FESP_FL_DATA_55;
               3'h2: seq_data = `FESP_FL_DATA_80;
               3'h3: seq_data = `FESP_FL_DATA_AA;
               3'h4: seq_data = `FESP_FL_DATA_55;
               default: seq_data = `FESP_FL_DATA_10;
            endcase
         end
      end
   endfunction

   wire cmd_wr = wr_in && (addr_in == `FESP_REG_CMD);

   // =========================================
   // Register reads, one cycle later
   always @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
         rdata_out <= 16'h0000;
      else if (rd_in)
      begin
         case (addr_in)
            `FESP_REG_STATUS: rdata_out <= {11'h000, ready_busy_n_in, refused, err, done, busy};
            `FESP_REG_ADDR: rdata_out <= user_addr[15:0];
            `FESP_REG_WDATA: rdata_out <= user_wdata;
            `FESP_REG_RDATA: rdata_out <= last_read;
            `FESP_REG_CTRL: rdata_out <= {15'h0000, fl_wp_n_out};
            default: rdata_out <= 16'h0000;
         endcase
      end
      else
         rdata_out <= 16'h0000;
   end

   // =========================================
   // Flash sequencer
   always @(posedge mclk_in or negedge resetn_in)
   begin
      if (!resetn_in)
      begin
         state <= S_IDLE;
         seq_idx <= 3'h0;
         seq_len <= 3'h0;
         cnt <= 4'h0;
         confirm <= 2'h0;
         polling <= 1'b0;
         single_read <= 1'b0;
         toggle_prev <= 1'b0;
         have_prev <= 1'b0;
         busy <= 1'b0;
         done <= 1'b0;
         err <= 1'b0;
         refused <= 1'b0;
         user_addr <= 20'h0_0000;
         user_wdata <= 16'h0000;
         last_read <= 16'h0000;
         fl_addr_out <= 20'h0_0000;
         fl_dq_out <= 16'h0000;
         fl_dq_oe_n_out <= 1'b1;
         fl_ce_n_out <= 1'b1;
         fl_we_n_out <= 1'b1;
         fl_oe_n_out <= 1'b1;
         fl_rst_n_out <= 1'b1;
         fl_wp_n_out <= 1'b1;
      end
      else
      begin
         // Local setup registers, ignored while busy
         if (wr_in && !busy && addr_in == `FESP_REG_ADDR)
            user_addr <= {4'h0, wdata_in};
         if (wr_in && !busy && addr_in == `FESP_REG_WDATA)
            user_wdata <= wdata_in;
         if (wr_in && !busy && addr_in == `FESP_REG_CTRL)
            fl_wp_n_out <= wdata_in[0];
         if (cmd_wr && polling && wdata_in[2:0] == `FESP_CMD_RESET)
         begin
            fl_rst_n_out <= 1'b0;
            fl_ce_n_out <= 1'b1;
            fl_oe_n_out <= 1'b1;
            cnt <= 4'h0;
            state <= S_RST;
         end
         else
         case (state)
            S_IDLE:
            begin
               fl_ce_n_out <= 1'b1;
               fl_we_n_out <= 1'b1;
               fl_oe_n_out <= 1'b1;
               fl_dq_oe_n_out <= 1'b1;
               if (cmd_wr)
               begin
                  busy <= 1'b1;
                  done <= 1'b0;
                  err <= 1'b0;
                  refused <= 1'b0;
                  cnt <= 4'h0;
                  seq_idx <= 3'h0;
                  have_prev <= 1'b0;
                  confirm <= 2'h0;
                  polling <= 1'b0;
                  single_read <= 1'b0;
                  case (wdata_in[2:0])
                     `FESP_CMD_CHIP_ERASE:
                     begin
                        if (!fl_wp_n_out)
                        begin
                           refused <= 1'b1;
                           busy <= 1'b0;
                        end
                        else
                        begin
                           seq_len <= 3'h6;
                           state <= S_WLOW;
                        end
                     end
                     `FESP_CMD_SUSPEND:
                     begin
                        seq_len <= 3'h1;
                        state <= S_WLOW;
                     end
                     `FESP_CMD_READ:
                     begin
                        single_read <= 1'b1;
                        fl_addr_out <= user_addr;
                        state <= S_RLOW;
                     end
                     `FESP_CMD_RESET:
                     begin
                        fl_rst_n_out <= 1'b0;
                        state <= S_RST;
                     end
                     default:
                     begin
                        busy <= 1'b0;
                        refused <= 1'b1;
                     end
                  endcase
               end
            end
            // select and strobe low, gate high
            S_WLOW:
            begin
               fl_addr_out <= seq_addr(seq_idx);
               fl_dq_out <= seq_data(seq_idx, seq_len);
               fl_dq_oe_n_out <= 1'b0;
               fl_oe_n_out <= 1'b1;
               fl_ce_n_out <= 1'b0;
               fl_we_n_out <= 1'b0;
               if (cnt == `FESP_PULSE_CYC)
               begin
                  cnt <= 4'h0;
                  fl_we_n_out <= 1'b1;
                  state <= S_WHIGH;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            S_WHIGH:
            begin
               fl_ce_n_out <= 1'b1;
               if (cnt == `FESP_PULSE_CYC)
               begin
                  cnt <= 4'h0;
                  fl_dq_oe_n_out <= 1'b1;
                  if (seq_idx == seq_len - 3'h1)
                  begin
                     if (seq_len == 3'h1)
                     begin
                        busy <= 1'b0;
                        done <= 1'b1;
                        state <= S_IDLE;
                     end
                     else
                     begin
                        polling <= 1'b1;
                        fl_addr_out <= user_addr;
                        state <= S_RLOW;
                     end
                  end
                  else
                  begin
                     seq_idx <= seq_idx + 3'h1;
                     state <= S_WLOW;
                  end
               end
               else
                  cnt <= cnt + 4'h1;
            end
            S_RLOW:
            begin
               fl_ce_n_out <= 1'b0;
               fl_oe_n_out <= 1'b0;
               if (cnt == `FESP_PULSE_CYC)
               begin
                  cnt <= 4'h0;
                  last_read <= fl_dq_in;
                  fl_oe_n_out <= 1'b1;
                  fl_ce_n_out <= 1'b1;
                  state <= S_RHIGH;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            S_RHIGH:
            begin
               state <= S_RLOW;
               have_prev <= 1'b1;
               toggle_prev <= last_read[`FESP_BIT_TOGGLE];
               if (single_read)
               begin
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
               else if (have_prev && toggle_prev == last_read[`FESP_BIT_TOGGLE])
               begin
                  if (last_read[`FESP_BIT_POLL] && confirm == 2'h2)
                  begin
                     cnt <= 4'h0;
                     state <= S_SETTLE;
                  end
                  else if (last_read[`FESP_BIT_POLL])
                     confirm <= confirm + 2'h1;
                  else
                     confirm <= 2'h0;
               end
               else
                  confirm <= 2'h0;
            end
            S_SETTLE:
            begin
               if (cnt == `FESP_SETTLE_CYC)
               begin
                  polling <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            S_RST:
            begin
               if (cnt == `FESP_RST_PULSE_CYC)
               begin
                  cnt <= 4'h0;
                  fl_rst_n_out <= 1'b1;
                  state <= S_REC;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            S_REC:
            begin
               if (cnt == `FESP_RST_REC_CYC)
               begin
                  err <= polling;
                  polling <= 1'b0;
                  busy <= 1'b0;
                  done <= 1'b1;
                  state <= S_IDLE;
               end
               else
                  cnt <= cnt + 4'h1;
            end
            default:
               state <= S_IDLE;
         endcase
      end
   end
endmodule
`default_nettype wire

// [verification/fesp_monitor.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Flash pin checker
module fesp_monitor
(
   // Clock and reset
   input wire logic mclk_in,
   input wire logic resetn_in,
   // Flash pins
   input wire logic [19:0] fl_addr_out,
   input wire logic [15:0] fl_dq_out,
   input wire logic fl_dq_oe_n_out,
   input wire logic fl_ce_n_out,
   input wire logic fl_we_n_out,
   input wire logic fl_oe_n_out,
   input wire logic fl_rst_n_out,
   input wire logic fl_wp_n_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (!resetn_in);
   write_gate_a: assert property (!fl_we_n_out |-> !fl_ce_n_out && fl_oe_n_out)
      else $error("write strobe outside select or with gate low");
   we_width_a: assert property ($fell(fl_we_n_out) |-> !fl_we_n_out [*2])
      else $error("write strobe too short");
   we_first_a: assert property ($rose(fl_we_n_out) |-> !fl_ce_n_out)
      else $error("select rose before write strobe");
   write_drive_a: assert property (!fl_we_n_out |-> !fl_dq_oe_n_out)
      else $error("data not driven during write");
   write_hold_a: assert property (!fl_we_n_out && $past(!fl_we_n_out)
      |-> $stable(fl_addr_out) && $stable(fl_dq_out))
      else $error("address or data moved in a write");
   read_release_a: assert property (!fl_oe_n_out |-> fl_dq_oe_n_out)
      else $error("data driven during read");
   wp_steady_a: assert property (!fl_we_n_out |-> $stable(fl_wp_n_out))
      else $error("protect moved in a sequence");
   rst_width_a: assert property ($fell(fl_rst_n_out) |-> !fl_rst_n_out [*8])
      else $error("flash reset pulse too short");
   rst_recover_a: assert property ($rose(fl_rst_n_out) |-> fl_ce_n_out [*8])
      else $error("access inside reset recovery");
endmodule
bind fesp_host fesp_monitor fesp_monitor_inst (.mclk_in(mclk_in), .resetn_in(resetn_in),
   .fl_addr_out(fl_addr_out), .fl_dq_out(fl_dq_out), .fl_dq_oe_n_out(fl_dq_oe_n_out),
   .fl_ce_n_out(fl_ce_n_out), .fl_we_n_out(fl_we_n_out), .fl_oe_n_out(fl_oe_n_out),
   .fl_rst_n_out(fl_rst_n_out), .fl_wp_n_out(fl_wp_n_out));
`default_nettype wire

// [verification/fesp_flash_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ==========
// Behavioural flash, erase and status only
module fesp_flash_model #(parameter int ERASE_CYC = 200)
(
   // Timing clock
   input wire logic clk_in,
   // Flash pins
   input wire logic ce_n_in,
   input wire logic we_n_in,
   input wire logic oe_n_in,
   input wire logic rst_n_in,
   input wire logic wp_n_in,
   input wire logic [19:0] addr_in,
   input wire logic [15:0] dq_in,
   output logic [15:0] dq_out,
   output logic rb_oe_n_out
);
   logic [19:0] sa [0:5] = '{20'h0_0555, 20'h0_02AA, 20'h0_0555, 20'h0_0555, 20'h0_02AA, 20'h0_0555};
   logic [15:0] sd [0:5] = '{16'h00AA, 16'h0055, 16'h0080, 16'h00AA, 16'h0055, 16'h0010};
   int step, cnt, settle, erase_count, susp_count, rst_count;
   logic busy = 0, erased = 0, t6 = 0, t2 = 0;
   logic [15:0] val, last = 16'h0000;
   logic [19:0] rd_addr;
   realtime fall_t;
   // Strobe start for the glitch filter
   always @(negedge we_n_in) fall_t = $realtime;
   always @(posedge we_n_in)
      if (!ce_n_in && oe_n_in && !busy && $realtime - fall_t >= 5.0)
      begin
         // no erase to suspend, plain data
         if (step == 0 && dq_in == 16'h00B0) susp_count++;
         step = (addr_in == sa[step] && dq_in == sd[step]) ? step + 1 : 0;
         if (step == 6 && wp_n_in)
         begin
            busy = 1;
            cnt = ERASE_CYC;
            erased = 0;
            erase_count++;
         end
         if (step == 6) step = 0;
      end
   always @(posedge clk_in)
   begin
      if (!rst_n_in)
      begin
         busy = 0;
         step = 0;
      end
      else if (busy)
      begin
         cnt = cnt - 1;
         if (cnt == 0)
         begin
            busy = 0;
            erased = 1;
            settle = 10;
         end
      end
      else if (settle > 0) settle = settle - 1;
   end
   // Address seen at each read start
   always @(negedge oe_n_in) rd_addr = addr_in;
   always @(negedge rst_n_in) rst_count++;
   always @(negedge oe_n_in)
      if (!ce_n_in && busy)
      begin
         t6 = !t6;
         t2 = !t2;
      end
   assign val = busy ? {9'h000, t6, 3'h0, t2, 2'h0} :
      (erased ? 16'hFFFF : 16'h5A5A) ^ (settle > 0 ? 16'hFF7F : 16'h0000);
   // Released bus shows the inverse of the last value
   always @(posedge oe_n_in) last = val;
   assign dq_out = (!ce_n_in && !oe_n_in) ? val : ~last;
   // open drain pulls low while busy
   assign rb_oe_n_out = !busy;
endmodule
`default_nettype wire

// [verification/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
`include "fesp_defs.vh"
// ==========
// Compare helper
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
   logic mclk_in = 0, resetn_in = 0, wr_in = 0, rd_in = 0, rd_seen = 0;
   logic [3:0] addr_in = 4'h0;
   logic [15:0] wdata_in = 16'h0000, v, m, mdq, rdata_out, fl_dq_out;
   logic [19:0] fl_addr_out;
   logic fl_dq_oe_n_out, fl_ce_n_out, fl_we_n_out, fl_oe_n_out, fl_rst_n_out, fl_wp_n_out, rb;
   wire logic [15:0] fl_dq_in;
   wire logic ready_busy_n_in;
   logic [15:0] exp_q [$], msk_q [$];
   int err_count, cmp_count, cycles, n0;
   logic [31:0] seed = 32'hef23, r;
   // Clock, bus resolution and pull-up
   always #50 mclk_in = !mclk_in;
   assign fl_dq_in = !fl_dq_oe_n_out ? fl_dq_out : mdq;
   assign ready_busy_n_in = rb ? 1'b1 : 1'b0;
   fesp_host fesp_host_inst (.mclk_in(mclk_in), .resetn_in(resetn_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .fl_addr_out(fl_addr_out), .fl_dq_in(fl_dq_in), .fl_dq_out(fl_dq_out),
      .fl_dq_oe_n_out(fl_dq_oe_n_out), .fl_ce_n_out(fl_ce_n_out), .fl_we_n_out(fl_we_n_out),
      .fl_oe_n_out(fl_oe_n_out), .fl_rst_n_out(fl_rst_n_out), .fl_wp_n_out(fl_wp_n_out),
      .ready_busy_n_in(ready_busy_n_in));
   fesp_flash_model fesp_flash_model_inst (.clk_in(mclk_in), .ce_n_in(fl_ce_n_out),
      .we_n_in(fl_we_n_out), .oe_n_in(fl_oe_n_out), .rst_n_in(fl_rst_n_out),
      .wp_n_in(fl_wp_n_out), .addr_in(fl_addr_out), .dq_in(fl_dq_in), .dq_out(mdq),
      .rb_oe_n_out(rb));
   // Register writes and reads
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] m, e, output logic [15:0] q);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      exp_q.push_back(e);
      msk_q.push_back(m);
      #1 q = rdata_out;
      @(posedge mclk_in);
   endtask
   task automatic cmd(input logic [2:0] c);
      wr(`FESP_REG_CMD, {13'h0000, c});
   endtask
   // Status polling until idle with done
   task automatic wait_done();
      v = 16'h0000;
      for (int i = 0; i < 3000 && !(v[1] === 1'b1 && v[0] === 1'b0); i++)
         rd(`FESP_REG_STATUS, 16'h0000, 16'h0000, v);
   endtask
   // Result watcher takes the oldest note
   always @(posedge mclk_in)
   begin
      rd_seen <= rd_in;
      if (rd_seen && msk_q.size() > 0)
      begin
         m = msk_q.pop_front();
         if (m != 16'h0000) `CHK(rdata_out & m, exp_q.pop_front())
         else void'(exp_q.pop_front());
      end
   end
   task automatic results();
      $display("compares %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Hang guard
   always @(posedge mclk_in)
   begin
      cycles <= cycles + 1;
      if (cycles == 30000)
      begin
         err_count++;
         results();
      end
   end
   initial
   begin
      repeat (8) @(posedge mclk_in);
      resetn_in <= 1'b1;
      @(posedge mclk_in);
      rd(`FESP_REG_STATUS, 16'h000F, 16'h0000, v);
      wr(`FESP_REG_CTRL, 16'h0001);
      r = $random(seed);
      wr(`FESP_REG_ADDR, r[15:0]);
      rd(`FESP_REG_ADDR, 16'hFFFF, r[15:0], v);
      cmd(`FESP_CMD_CHIP_ERASE);
      repeat (20) @(posedge mclk_in);
      cmd(`FESP_CMD_CHIP_ERASE);
      repeat (30) @(posedge mclk_in);
      rd(`FESP_REG_STATUS, 16'h0011, 16'h0001, v);
      wait_done();
      rd(`FESP_REG_STATUS, 16'h001F, 16'h0012, v);
      `CHK(fesp_flash_model_inst.erase_count, 1)
      cmd(`FESP_CMD_READ);
      wait_done();
      rd(`FESP_REG_RDATA, 16'hFFFF, 16'hFFFF, v);
      `CHK(fesp_flash_model_inst.rd_addr, {4'h0, r[15:0]})
      for (int c = 5; c <= 8; c++)
      begin
         cmd(c[2:0]);
         rd(`FESP_REG_STATUS, 16'h0008, 16'h0008, v);
      end
      wr(`FESP_REG_CTRL, 16'h0000);
      cmd(`FESP_CMD_CHIP_ERASE);
      repeat (2) @(posedge mclk_in);
      rd(`FESP_REG_STATUS, 16'h0008, 16'h0008, v);
      `CHK(fesp_flash_model_inst.erase_count, 1)
      wr(`FESP_REG_CTRL, 16'h0001);
      cmd(`FESP_CMD_SUSPEND);
      wait_done();
      `CHK(fesp_flash_model_inst.susp_count, 1)
      n0 = fesp_flash_model_inst.rst_count;
      cmd(`FESP_CMD_RESET);
      wait_done();
      `CHK(fesp_flash_model_inst.rst_count, n0 + 1)
      rd(`FESP_REG_STATUS, 16'h0004, 16'h0000, v);
      cmd(`FESP_CMD_CHIP_ERASE);
      repeat (60) @(posedge mclk_in);
      cmd(`FESP_CMD_RESET);
      wait_done();
      rd(`FESP_REG_STATUS, 16'h0004, 16'h0004, v);
      `CHK(fesp_flash_model_inst.rst_count, n0 + 2)
      cmd(`FESP_CMD_CHIP_ERASE);
      wait_done();
      rd(`FESP_REG_STATUS, 16'h0007, 16'h0002, v);
      `CHK(fesp_flash_model_inst.erase_count, 3)
      results();
   end
endmodule
`default_nettype wire
